// ---- core/lcsc_charger.v ----
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "lcsc_consts.vh"
module lcsc_charger #(
    parameter [31:0] MINUTE_CYCLES = `LCSC_MINUTE_CYCLES
) (
    clk,
    nrst,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    inputUnder,
    inputOver,
    battAboveRestart,
    battAbovePq,
    battAtTarget,
    currBelowTerm,
    currBelowFifth,
    supplementActive,
    inputLoopActive,
    loadLoopActive,
    dieThrottleActive,
    battTempFault,
    battTempModified,
    battConnect,
    chargeOn,
    prechargeRate,
    holdVoltage,
    modifiedParams,
    prechargeRateSel,
    prechargeThresholdSel,
    inputVoltageFloorSel,
    dieTempLimitSel,
    termSel,
    fastCurrentSel,
    targetVoltageSel,
    chargerIrq
);
    input wire clk;
    input wire nrst;
    input wire [5:0] s_axi_awaddr;
    input wire s_axi_awvalid;
    output reg s_axi_awready;
    input wire [31:0] s_axi_wdata;
    input wire [3:0] s_axi_wstrb;
    input wire s_axi_wvalid;
    output reg s_axi_wready;
    output reg [1:0] s_axi_bresp;
    output reg s_axi_bvalid;
    input wire s_axi_bready;
    input wire [5:0] s_axi_araddr;
    input wire s_axi_arvalid;
    output reg s_axi_arready;
    output reg [31:0] s_axi_rdata;
    output reg [1:0] s_axi_rresp;
    output reg s_axi_rvalid;
    input wire s_axi_rready;
    input wire inputUnder;
    input wire inputOver;
    input wire battAboveRestart;
    input wire battAbovePq;
    input wire battAtTarget;
    input wire currBelowTerm;
    input wire currBelowFifth;
    input wire supplementActive;
    input wire inputLoopActive;
    input wire loadLoopActive;
    input wire dieThrottleActive;
    input wire battTempFault;
    input wire battTempModified;
    output reg battConnect;
    output reg chargeOn;
    output reg prechargeRate;
    output reg holdVoltage;
    output reg modifiedParams;
    output reg prechargeRateSel;
    output reg [2:0] prechargeThresholdSel;
    output reg [2:0] inputVoltageFloorSel;
    output reg [2:0] dieTempLimitSel;
    output reg [1:0] termSel;
    output reg [5:0] fastCurrentSel;
    output reg [5:0] targetVoltageSel;
    output reg chargerIrq;

    localparam [3:0] ST_OFF = 4'h0;
    localparam [3:0] ST_PRE = 4'h1;
    localparam [3:0] ST_CC = 4'h2;
    localparam [3:0] ST_CC_MOD = 4'h3;
    localparam [3:0] ST_CV = 4'h4;
    localparam [3:0] ST_CV_MOD = 4'h5;
    localparam [3:0] ST_TOPOFF = 4'h6;
    localparam [3:0] ST_DONE = 4'h7;
    localparam [3:0] ST_FRESH = 4'h8;
    localparam [3:0] ST_PQ_FAULT = 4'h9;
    localparam [3:0] ST_FC_FAULT = 4'hA;
    localparam [3:0] ST_TEMP_FAULT = 4'hB;

    localparam [1:0] RESP_OKAY = 2'h0;
    localparam [1:0] RESP_SLVERR = 2'h2;
    localparam [31:0] PQ_LIMIT_WIDE = `LCSC_PQ_TIME_MIN;
    localparam [5:0] PQ_LIMIT = PQ_LIMIT_WIDE[5:0];
    localparam NSYNC = 13;

    ////////////////////////////////////////////////////////////////////////////
    // functions

    function isFast;
        input [3:0] st;
        begin
            isFast = (st == ST_CC) || (st == ST_CC_MOD) || (st == ST_CV) || (st == ST_CV_MOD);
        end
    endfunction

    function isCharging;
        input [3:0] st;
        begin
            isCharging = isFast(st) || (st == ST_PRE) || (st == ST_TOPOFF);
        end
    endfunction

    function [31:0] applyStrb;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            applyStrb = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    applyStrb[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // safety limit in minutes: 3, 5 or 7 hours
    function [8:0] safetyLimit;
        input [1:0] sel;
        reg [31:0] hours;
        reg [31:0] minutes;
        begin
            hours = `LCSC_SAFETY_BASE_H + `LCSC_SAFETY_STEP_H * ({30'd0, sel} - 32'd1);
            minutes = hours * `LCSC_MIN_PER_H;
            safetyLimit = minutes[8:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    reg [NSYNC-1:0] syncA_reg;
    reg [NSYNC-1:0] syncB_reg;
    wire [NSYNC-1:0] pinsRaw;
    assign pinsRaw = {battTempModified, battTempFault, dieThrottleActive, loadLoopActive,
                      inputLoopActive, supplementActive, currBelowFifth, currBelowTerm,
                      battAtTarget, battAbovePq, battAboveRestart, inputOver, inputUnder};

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // input reads invalid until real pin levels pass both flops, so no charge blip
            syncA_reg <= `LCSC_SYNC_RESET;
            syncB_reg <= `LCSC_SYNC_RESET;
        end else begin
            syncA_reg <= pinsRaw;
            syncB_reg <= syncA_reg;
        end
    end

    wire sUnder = syncB_reg[0];
    wire sOver = syncB_reg[1];
    wire sAboveRestart = syncB_reg[2];
    wire sAbovePq = syncB_reg[3];
    wire sAtTarget = syncB_reg[4];
    wire sBelowTerm = syncB_reg[5];
    wire sBelowFifth = syncB_reg[6];
    wire sSupplement = syncB_reg[7];
    wire sInputLoop = syncB_reg[8];
    wire sLoadLoop = syncB_reg[9];
    wire sThrottle = syncB_reg[10];
    wire sTempFault = syncB_reg[11];
    wire sTempMod = syncB_reg[12];
    wire inputValid = !sUnder && !sOver;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    reg [31:0] cfgA_reg;
    reg [31:0] cfgB_reg;
    reg [3:0] irq_reg;
    reg [3:0] mask_reg;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [3:0] saved_reg;
    reg [5:0] pqMin_reg;
    reg [8:0] safetyMin_reg;
    reg [5:0] topMin_reg;
    reg [2:0] loopPrev_reg;
    reg [5:0] awAddr_reg;
    reg [31:0] wData_reg;
    reg [3:0] wStrb_reg;
    wire minuteTick;

    wire chgEn = cfgA_reg[`LCSC_CFGA_EN_BIT];
    wire [1:0] safetySel = cfgA_reg[`LCSC_CFGA_SAFETY_LSB +: 2];
    wire [2:0] topSel = cfgA_reg[`LCSC_CFGA_TOPOFF_LSB +: 3];
    wire [31:0] topLimitWide = {29'h0, topSel} * `LCSC_TOPOFF_STEP_MIN;
    wire [5:0] topLimit = topLimitWide[5:0];
    wire pqExpired = pqMin_reg >= PQ_LIMIT;
    wire safetyExpired = (safetySel != 2'h0)
                         && (safetyMin_reg >= safetyLimit(safetySel));
    wire topExpired = topMin_reg >= topLimit;
    wire safetyPaused = (((state_reg == ST_CC) || (state_reg == ST_CC_MOD)) && sBelowFifth)
                        || sSupplement || (state_reg == ST_TEMP_FAULT);
    wire [3:0] ccState = sTempMod ? ST_CC_MOD : ST_CC;
    wire [3:0] cvState = sTempMod ? ST_CV_MOD : ST_CV;
    wire [3:0] startState = sAbovePq ? ccState : ST_PRE;
    wire [1:0] qualCode = sUnder ? `LCSC_QUAL_UNDER : (sOver ? `LCSC_QUAL_OVER : `LCSC_QUAL_OK);

    lcsc_minute_tick #(
        .MINUTE_CYCLES(MINUTE_CYCLES)
    ) u_tick (
        .clk(clk),
        .nrst(nrst),
        .tick(minuteTick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // charge state machine

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                state_next = sAboveRestart ? ST_FRESH : startState;
            end
            ST_FRESH, ST_DONE: begin
                if (!sAboveRestart) begin
                    state_next = startState;
                end
            end
            ST_PRE: begin
                if (pqExpired) begin
                    state_next = ST_PQ_FAULT;
                end else if (sAbovePq) begin
                    state_next = ccState;
                end
            end
            ST_CC, ST_CC_MOD: begin
                if (safetyExpired) begin
                    state_next = ST_FC_FAULT;
                end else if (sAtTarget) begin
                    state_next = cvState;
                end else begin
                    state_next = ccState;
                end
            end
            ST_CV, ST_CV_MOD: begin
                if (safetyExpired) begin
                    state_next = ST_FC_FAULT;
                end else if (sBelowTerm) begin
                    state_next = ST_TOPOFF;
                end else begin
                    state_next = cvState;
                end
            end
            ST_TOPOFF: begin
                if (topExpired) begin
                    state_next = ST_DONE;
                end
            end
            ST_PQ_FAULT, ST_FC_FAULT: begin
                state_next = state_reg;
            end
            ST_TEMP_FAULT: begin
                if (!sTempFault) begin
                    state_next = saved_reg;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        if (isCharging(state_reg) && sTempFault) begin
            state_next = ST_TEMP_FAULT;
        end
        if (!inputValid || !chgEn) begin
            state_next = ST_OFF;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_OFF;
            saved_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
            if (state_next == ST_TEMP_FAULT && state_reg != ST_TEMP_FAULT) begin
                saved_reg <= state_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timers; minute granularity, first tick may come early by up to a minute

    wire leavingTemp = (state_reg == ST_TEMP_FAULT) && (state_next != ST_TEMP_FAULT);

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pqMin_reg <= 6'h00;
            safetyMin_reg <= 9'h000;
            topMin_reg <= 6'h00;
        end else begin
            if (state_next == ST_PRE && state_reg != ST_PRE && state_reg != ST_TEMP_FAULT) begin
                pqMin_reg <= 6'h00;
            end else if (state_reg == ST_PRE && minuteTick && pqMin_reg != 6'h3F) begin
                pqMin_reg <= pqMin_reg + 6'h01;
            end
            if (leavingTemp
                || (isFast(state_next) && !isFast(state_reg) && state_reg != ST_TEMP_FAULT)) begin
                safetyMin_reg <= 9'h000;
            end else if (isFast(state_reg) && !safetyPaused && minuteTick
                         && safetyMin_reg != 9'h1FF) begin
                safetyMin_reg <= safetyMin_reg + 9'h001;
            end
            if (leavingTemp || (state_next == ST_TOPOFF && state_reg != ST_TOPOFF)) begin
                topMin_reg <= 6'h00;
            end else if (state_reg == ST_TOPOFF && minuteTick && topMin_reg != 6'h3F) begin
                topMin_reg <= topMin_reg + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power path controls and configuration outputs

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            battConnect <= 1'b1;
            chargeOn <= 1'b0;
            prechargeRate <= 1'b0;
            holdVoltage <= 1'b0;
            modifiedParams <= 1'b0;
        end else begin
            if (!inputValid) begin
                battConnect <= 1'b1;
            end else begin
                battConnect <= isCharging(state_reg);
            end
            chargeOn <= isCharging(state_reg);
            prechargeRate <= state_reg == ST_PRE;
            holdVoltage <= (state_reg == ST_CV) || (state_reg == ST_CV_MOD)
                           || (state_reg == ST_TOPOFF);
            modifiedParams <= (state_reg == ST_CC_MOD) || (state_reg == ST_CV_MOD);
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prechargeRateSel <= 1'b0;
            prechargeThresholdSel <= 3'h0;
            inputVoltageFloorSel <= 3'h0;
            dieTempLimitSel <= 3'h0;
            termSel <= 2'h0;
            fastCurrentSel <= 6'h00;
            targetVoltageSel <= 6'h00;
        end else begin
            prechargeRateSel <= cfgA_reg[`LCSC_CFGA_PQRATE_BIT];
            prechargeThresholdSel <= cfgA_reg[`LCSC_CFGA_PQTHR_LSB +: 3];
            inputVoltageFloorSel <= cfgA_reg[`LCSC_CFGA_VFLOOR_LSB +: 3];
            dieTempLimitSel <= cfgA_reg[`LCSC_CFGA_TJLIM_LSB +: 3];
            termSel <= cfgA_reg[`LCSC_CFGA_TERM_LSB +: 2];
            fastCurrentSel <= cfgB_reg[`LCSC_CFGB_CURR_LSB +: 6];
            targetVoltageSel <= cfgB_reg[`LCSC_CFGB_VOLT_LSB +: 6];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // events; a new event beats a clear in the same cycle

    wire [3:0] irqEvent;
    assign irqEvent[`LCSC_IRQ_INPUT] = sInputLoop && !loopPrev_reg[0];
    assign irqEvent[`LCSC_IRQ_LOAD] = sLoadLoop != loopPrev_reg[1];
    assign irqEvent[`LCSC_IRQ_THERMAL] = sThrottle != loopPrev_reg[2];
    assign irqEvent[`LCSC_IRQ_STATE] = state_next != state_reg;

    wire doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire [3:0] irqClear = (doWrite && awAddr_reg == `LCSC_ADDR_IRQ && wStrb_reg[0])
                          ? wData_reg[3:0] : 4'h0;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loopPrev_reg <= 3'h0;
            irq_reg <= 4'h0;
            chargerIrq <= 1'b0;
        end else begin
            loopPrev_reg <= {sThrottle, sLoadLoop, sInputLoop};
            irq_reg <= (irq_reg & ~irqClear) | irqEvent;
            chargerIrq <= |(irq_reg & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    wire mapped = (awAddr_reg == `LCSC_ADDR_CFG_A) || (awAddr_reg == `LCSC_ADDR_CFG_B)
                  || (awAddr_reg == `LCSC_ADDR_STATUS_FIRST)
                  || (awAddr_reg == `LCSC_ADDR_STATUS_SECOND)
                  || (awAddr_reg == `LCSC_ADDR_IRQ) || (awAddr_reg == `LCSC_ADDR_MASK);

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awAddr_reg <= 6'h00;
            wData_reg <= 32'h00000000;
            wStrb_reg <= 4'h0;
            cfgA_reg <= `LCSC_CFGA_RESET;
            cfgB_reg <= `LCSC_CFGB_RESET;
            mask_reg <= `LCSC_MASK_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_reg <= {s_axi_awaddr[5:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped ? RESP_OKAY : RESP_SLVERR;
                if (awAddr_reg == `LCSC_ADDR_CFG_A) begin
                    cfgA_reg <= applyStrb(cfgA_reg, wData_reg, wStrb_reg) & `LCSC_CFGA_MASK;
                end
                if (awAddr_reg == `LCSC_ADDR_CFG_B) begin
                    cfgB_reg <= applyStrb(cfgB_reg, wData_reg, wStrb_reg) & `LCSC_CFGB_MASK;
                end
                if (awAddr_reg == `LCSC_ADDR_MASK && wStrb_reg[0]) begin
                    mask_reg <= wData_reg[3:0];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    reg [31:0] readData;
    reg readOk;
    always @* begin
        readData = 32'h00000000;
        readOk = 1'b1;
        case ({s_axi_araddr[5:2], 2'b00})
            `LCSC_ADDR_CFG_A: readData = cfgA_reg;
            `LCSC_ADDR_CFG_B: readData = cfgB_reg;
            `LCSC_ADDR_STATUS_FIRST: begin
                readData = {29'h0, sThrottle, sLoadLoop, sInputLoop};
            end
            `LCSC_ADDR_STATUS_SECOND: begin
                readData = {25'h0, qualCode, safetyPaused, state_reg};
            end
            `LCSC_ADDR_IRQ: readData = {28'h0, irq_reg};
            `LCSC_ADDR_MASK: readData = {28'h0, mask_reg};
            default: readOk = 1'b0;
        endcase
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readData;
            s_axi_rresp <= readOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // lcsc_charger

// ---- core/lcsc_consts.vh ----
`ifndef LCSC_CONSTS_VH
`define LCSC_CONSTS_VH

// register byte offsets
`define LCSC_ADDR_CFG_A 6'h00
`define LCSC_ADDR_CFG_B 6'h04
`define LCSC_ADDR_STATUS_FIRST 6'h08
`define LCSC_ADDR_STATUS_SECOND 6'h0C
`define LCSC_ADDR_IRQ 6'h10
`define LCSC_ADDR_MASK 6'h14

// configuration A field positions
`define LCSC_CFGA_EN_BIT 0
`define LCSC_CFGA_PQRATE_BIT 1
`define LCSC_CFGA_PQTHR_LSB 2
`define LCSC_CFGA_VFLOOR_LSB 5
`define LCSC_CFGA_TJLIM_LSB 8
`define LCSC_CFGA_TERM_LSB 11
`define LCSC_CFGA_SAFETY_LSB 13
`define LCSC_CFGA_TOPOFF_LSB 15
`define LCSC_CFGA_MASK 32'h0003FFFF
// configuration B field positions
`define LCSC_CFGB_CURR_LSB 0
`define LCSC_CFGB_VOLT_LSB 8
`define LCSC_CFGB_MASK 32'h00003F3F

// reset values
`define LCSC_CFGA_RESET 32'h00002001
`define LCSC_CFGB_RESET 32'h00000F0F
`define LCSC_MASK_RESET 4'hF
// pin synchroniser start value: bit 0 reads as input under lockout
`define LCSC_SYNC_RESET 13'h0001

// irq bit positions
`define LCSC_IRQ_INPUT 0
`define LCSC_IRQ_LOAD 1
`define LCSC_IRQ_THERMAL 2
`define LCSC_IRQ_STATE 3

// input quality codes
`define LCSC_QUAL_UNDER 2'h0
`define LCSC_QUAL_OVER 2'h1
`define LCSC_QUAL_OK 2'h3

// timing
`define LCSC_CLK_HZ 10000000
`define LCSC_MINUTE_S 60
`define LCSC_MINUTE_CYCLES (`LCSC_CLK_HZ * `LCSC_MINUTE_S)
`define LCSC_PQ_TIME_MIN 30
`define LCSC_SAFETY_BASE_H 3
`define LCSC_SAFETY_STEP_H 2
`define LCSC_MIN_PER_H 60
`define LCSC_TOPOFF_STEP_MIN 5

`endif

// ---- core/lcsc_minute_tick.v ----
`timescale 1ns/10ps
// one-cycle pulse every MINUTE_CYCLES clocks
module lcsc_minute_tick #(
    parameter [31:0] MINUTE_CYCLES = 32'd600000000
) (
    clk,
    nrst,
    tick
);
    input wire clk;
    input wire nrst;
    output reg tick;

    reg [31:0] count_reg;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 32'h00000000;
            tick <= 1'b0;
        end else if (count_reg >= MINUTE_CYCLES - 32'd1) begin
            count_reg <= 32'h00000000;
            tick <= 1'b1;
        end else begin
            count_reg <= count_reg + 32'd1;
            tick <= 1'b0;
        end
    end
endmodule // lcsc_minute_tick

// ---- tb/lcsc_charger_asserts.sv ----
`timescale 1ns/10ps
module lcsc_charger_asserts (
    input wire clk,
    input wire nrst,
    input wire inputUnder,
    input wire inputOver,
    input wire battConnect,
    input wire chargeOn,
    input wire prechargeRate,
    input wire holdVoltage,
    input wire s_axi_bvalid,
    input wire [5:0] fastCurrentSel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire bad = inputUnder | inputOver;
    // pins need two sync flops, a state edge and an output edge
    sequence badRun; bad [*5]; endsequence
    sequence goodRun; !bad [*5]; endsequence
    inv_link_a: assert property (badRun |=> battConnect) else $error("link");
    inv_off_a: assert property (badRun |=> !chargeOn) else $error("on");
    inv_react_a: assert property ($rose(bad) |-> ##[3:5] battConnect && !chargeOn)
        else $error("react");
    idle_cut_a: assert property (goodRun ##0 ($past(nrst, 8) && !chargeOn)
        |-> !battConnect) else $error("idle");
    charge_link_a: assert property (chargeOn |-> battConnect)
        else $error("cut");
    pre_rate_a: assert property (prechargeRate |-> chargeOn && !holdVoltage)
        else $error("rate");
    hold_on_a: assert property (holdVoltage |-> chargeOn) else $error("hold");
    // the copy lands one edge after the register, which lands as bvalid rises
    cfg_copy_a: assert property ($past(nrst, 2) && $changed(fastCurrentSel)
        |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)) else $error("copy");
endmodule // lcsc_charger_asserts
bind lcsc_charger lcsc_charger_asserts lcsc_charger_asserts_i (.clk, .nrst, .inputUnder,
    .inputOver, .battConnect, .chargeOn, .prechargeRate, .holdVoltage, .s_axi_bvalid,
    .fastCurrentSel);

// ---- tb/lcsc_cell.sv ----
`timescale 1ns/10ps
// cell voltage climbs only while charge current flows
module lcsc_cell (
    input wire clk,
    input wire chargeOn,
    input wire holdVoltage,
    output wire battAbovePq,
    output wire battAboveRestart,
    output wire battAtTarget,
    output wire currBelowTerm
);
    int lvl = 0;
    bit stall = 0;
    int held = 0;
    always @(posedge clk) begin
        if (chargeOn && !holdVoltage && !stall && lvl < 100) lvl <= lvl + 1;
        held <= holdVoltage ? held + 1 : 0;
    end
    assign battAbovePq = lvl > 30;
    assign battAboveRestart = lvl > 95;
    assign battAtTarget = lvl > 99;
    // taper: current drops under termination a few cycles into hold
    assign currBelowTerm = held > 8;
endmodule // lcsc_cell

// ---- tb/lcsc_charger_test.sv ----
`timescale 1ns/10ps
`include "lcsc_consts.vh"
module lcsc_charger_test;
    logic clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, inputUnder = 1, inputOver = 0;
    logic supplementActive = 0, inputLoopActive = 0, loadLoopActive = 0, dieThrottleActive = 0;
    logic currBelowFifth = 0, battTempFault = 0, battTempModified = 0;
    logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, rd;
    logic [1:0] rsp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, chargerIrq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire battConnect, chargeOn, prechargeRate, holdVoltage;
    wire battAbovePq, battAboveRestart, battAtTarget, currBelowTerm;
    int err_count = 0, check_count = 0;
    always #50 clk = ~clk;
    // a 20-cycle minute keeps the 3 hour safety timer at 3600 cycles
    lcsc_charger #(.MINUTE_CYCLES(32'h00000014)) lcsc_charger_i (.*, .s_axi_wstrb(4'hF),
        .modifiedParams(), .prechargeRateSel(), .prechargeThresholdSel(),
        .inputVoltageFloorSel(), .dieTempLimitSel(), .termSel(), .fastCurrentSel(),
        .targetVoltageSel());
    lcsc_cell lcsc_cell_i (.*);
    ////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic acc(input bit w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 40);
        s_axi_bready <= 0;
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rsp = w ? s_axi_bresp : s_axi_rresp;
        chk("timeout", 0, n / 40);
        if (n >= 40) stop_test;
    endtask
    task automatic wait_code(input logic [3:0] c);
        int n;
        n = 0;
        do begin
            acc(0, `LCSC_ADDR_STATUS_SECOND, 0);
            n++;
        end while (rd[3:0] !== c && n < 3000);
        chk("state", c, rd[3:0]);
        if (n >= 3000) stop_test;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1;
        acc(0, `LCSC_ADDR_CFG_A, 0);
        chk("cfgA", `LCSC_CFGA_RESET, rd);
        acc(1, `LCSC_ADDR_CFG_B, 32'h00000F10);
        acc(0, 6'h18, 0);
        chk("unmapped", 2'h2, rsp);
        wait_code(4'h0);
        for (int i = 0; i < 3; i++) begin
            {dieThrottleActive, loadLoopActive, inputLoopActive} <= 3'h1 << i;
            repeat (5) @(posedge clk);
            acc(0, `LCSC_ADDR_STATUS_FIRST, 0);
            chk("status", 32'h1 << i, rd);
            acc(0, `LCSC_ADDR_IRQ, 0);
            chk("irq", 1, rd[i]);
            acc(1, `LCSC_ADDR_IRQ, 32'h0000000F);
            acc(0, `LCSC_ADDR_IRQ, 0);
            chk("irqClr", 0, rd[i]);
        end
        lcsc_cell_i.lvl <= 99;
        inputUnder <= 0;
        wait_code(4'h8);
        lcsc_cell_i.lvl <= 90;
        wait_code(4'h7);
        acc(0, `LCSC_ADDR_IRQ, 0);
        chk("stateIrq", 1, rd[3]);
        chk("unmasked", 1, chargerIrq);
        acc(1, `LCSC_ADDR_MASK, 0);
        @(posedge clk);
        chk("masked", 0, chargerIrq);
        acc(1, `LCSC_ADDR_MASK, 32'h0000000F);
        lcsc_cell_i.stall <= 1;
        lcsc_cell_i.lvl <= 90;
        wait_code(4'h2);
        chk("running", 0, rd[4]);
        battTempModified <= 1;
        wait_code(4'h3);
        battTempFault <= 1;
        wait_code(4'hB);
        chk("tempPause", 1, rd[4]);
        battTempFault <= 0;
        wait_code(4'h3);
        battTempModified <= 0;
        wait_code(4'h2);
        supplementActive <= 1;
        acc(0, `LCSC_ADDR_STATUS_SECOND, 0);
        acc(0, `LCSC_ADDR_STATUS_SECOND, 0);
        chk("paused", 1, rd[4]);
        supplementActive <= 0;
        currBelowFifth <= 1;
        acc(0, `LCSC_ADDR_STATUS_SECOND, 0);
        acc(0, `LCSC_ADDR_STATUS_SECOND, 0);
        chk("lowCurr", 1, rd[4]);
        currBelowFifth <= 0;
        wait_code(4'hA);
        acc(1, `LCSC_ADDR_CFG_A, 32'h00002000);
        wait_code(4'h0);
        lcsc_cell_i.lvl <= 5;
        acc(1, `LCSC_ADDR_CFG_A, `LCSC_CFGA_RESET);
        wait_code(4'h1);
        wait_code(4'h9);
        inputUnder <= 1;
        wait_code(4'h0);
        stop_test;
    end
endmodule // lcsc_charger_test
